// ### verilog/acfg_top.sv
// Limiter attack configuration registers behind a serial two-wire slave
`timescale 1ns/1ps
// Functional notes
// - Mid register at 0x09, rate bits 4:2
// - Mid rate codes map 0.16..164 ms/dB, reset 010
// - Fast rate bits 3:2, 0.04..0.32, reset 01
// - Fast register 0x0A, reserved 1001/1, disable bit0
module acfg_top #(
  parameter logic [6:0] DEV_ADDR = acfg_pkg::ACFG_DEV_ADDR_DFLT
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic [2:0] MID_LEVEL_ATTACK_RATE,
  output logic [1:0] FAST_LEVEL_ATTACK_RATE,
  output logic FAST_LEVEL_LIMITER_OFF,
  output logic [acfg_pkg::ACFG_RATE_W-1:0] MID_LEVEL_ATTACK_TIME,
  output logic [acfg_pkg::ACFG_RATE_W-1:0] FAST_LEVEL_ATTACK_TIME
);
  import acfg_pkg::*;

  // ==========================================================
  // Pin synchronisation and edge detection
  logic [1:0] pins_lvl;
  logic scl;
  logic sda;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  acfg_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .pin_in({SCL_IN, SDA_IN}),
    .level_out(pins_lvl)
  );

  assign scl = pins_lvl[1];
  assign sda = pins_lvl[0];

  // Data line moving while the clock is high marks start or stop
  assign scl_rise = scl & ~scl_prev_q;
  assign scl_fall = ~scl & scl_prev_q;
  assign start_cond = scl & scl_prev_q & ~sda & sda_prev_q;
  assign stop_cond = scl & scl_prev_q & sda & ~sda_prev_q;

  // ==========================================================
  // Configuration fields and read mux
  logic [2:0] mid_rate_q;
  logic [2:0] mid_rate_d;
  logic [1:0] fast_rate_q;
  logic [1:0] fast_rate_d;
  logic fast_off_q;
  logic fast_off_d;
  logic [7:0] rd_byte;
  acfg_state_type state_q;
  acfg_state_type state_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic rw_q;
  logic rw_d;
  logic nack_q;
  logic nack_d;
  logic oe_q;
  logic oe_d;
  logic [ACFG_RATE_W-1:0] mid_time_q;
  logic [ACFG_RATE_W-1:0] mid_time_d;
  logic [ACFG_RATE_W-1:0] fast_time_q;
  logic [ACFG_RATE_W-1:0] fast_time_d;

  // Reserved bits are constants, so what a read returns cannot drift
  always_comb
  begin
    if (ptr_q == ACFG_MID_LEVEL_LIMITER_TIMING_ADDR)
    begin
      rd_byte = {ACFG_MID_RSVD_HI, mid_rate_q, ACFG_MID_RSVD_LO};
    end
    else if (ptr_q == ACFG_FAST_LEVEL_LIMITER_CONTROL_ADDR)
    begin
      rd_byte = {ACFG_FAST_RSVD_HI, fast_rate_q, ACFG_FAST_RSVD_B1, fast_off_q};
    end
    else
    begin
      rd_byte = 8'h00; // Unmapped pointer reads as zero
    end
  end

  // ==========================================================
  // Serial slave state
  // Bytes are sampled on clock rise; the line is changed only after clock fall
  always_comb
  begin
    state_d = state_q;
    bit_d = bit_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    nack_d = nack_q;
    oe_d = oe_q;
    mid_rate_d = mid_rate_q;
    fast_rate_d = fast_rate_q;
    fast_off_d = fast_off_q;
    mid_time_d = acfg_mid_rate(mid_rate_q);
    fast_time_d = acfg_fast_rate(fast_rate_q);
    if (start_cond)
    begin
      state_d = ACFG_ADDR;
      bit_d = 4'h0;
      oe_d = 1'b0;
    end
    else if (stop_cond)
    begin
      state_d = ACFG_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      case (state_q)
        ACFG_ADDR, ACFG_PTR, ACFG_WR:
        begin
          if (scl_rise)
          begin
            shift_d = {shift_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end
          else if (scl_fall && bit_q == ACFG_BITS_PER_BYTE)
          begin
            oe_d = 1'b1; // Acknowledge by pulling low
            if (state_q == ACFG_ADDR)
            begin
              if (shift_q[7:1] == DEV_ADDR)
              begin
                rw_d = shift_q[0];
                state_d = ACFG_ADDR_ACK;
              end
              else
              begin
                oe_d = 1'b0; // Another device is addressed
                state_d = ACFG_IDLE;
              end
            end
            else if (state_q == ACFG_PTR)
            begin
              ptr_d = shift_q;
              state_d = ACFG_PTR_ACK;
            end
            else
            begin
              // Only the fields are stored; reserved bits of the byte are dropped
              if (ptr_q == ACFG_MID_LEVEL_LIMITER_TIMING_ADDR)
              begin
                mid_rate_d = shift_q[ACFG_MID_RATE_MSB:ACFG_MID_RATE_LSB];
              end
              else if (ptr_q == ACFG_FAST_LEVEL_LIMITER_CONTROL_ADDR)
              begin
                fast_rate_d = shift_q[ACFG_FAST_RATE_MSB:ACFG_FAST_RATE_LSB];
                fast_off_d = shift_q[ACFG_FAST_OFF_BIT];
              end
              ptr_d = ptr_q + 8'h01;
              state_d = ACFG_WR_ACK;
            end
          end
        end
        ACFG_ADDR_ACK, ACFG_PTR_ACK, ACFG_WR_ACK:
        begin
          if (scl_fall)
          begin
            bit_d = 4'h0;
            if (state_q == ACFG_ADDR_ACK && rw_q)
            begin
              shift_d = rd_byte;
              ptr_d = ptr_q + 8'h01;
              oe_d = ~rd_byte[7];
              state_d = ACFG_RD;
            end
            else
            begin
              oe_d = 1'b0;
              state_d = (state_q == ACFG_ADDR_ACK) ? ACFG_PTR : ACFG_WR;
            end
          end
        end
        ACFG_RD:
        begin
          if (scl_fall)
          begin
            if (bit_q == ACFG_BITS_PER_BYTE - 4'h1)
            begin
              oe_d = 1'b0; // Release for the master's acknowledge
              state_d = ACFG_RD_ACK;
            end
            else
            begin
              shift_d = {shift_q[6:0], 1'b0};
              oe_d = ~shift_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        ACFG_RD_ACK:
        begin
          if (scl_rise)
          begin
            nack_d = sda;
          end
          else if (scl_fall)
          begin
            bit_d = 4'h0;
            if (nack_q)
            begin
              state_d = ACFG_IDLE;
            end
            else
            begin
              shift_d = rd_byte;
              ptr_d = ptr_q + 8'h01;
              oe_d = ~rd_byte[7];
              state_d = ACFG_RD;
            end
          end
        end
        default:
        begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // Fields take their defaults at reset
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q <= ACFG_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      mid_rate_q <= ACFG_MID_RATE_RST;
      fast_rate_q <= ACFG_FAST_RATE_RST;
      fast_off_q <= ACFG_FAST_OFF_RST;
      scl_prev_q <= 1'b1; // Idle high, so no false edge after reset
      sda_prev_q <= 1'b1;
      mid_time_q <= 15'h0040;
      fast_time_q <= 15'h0008;
    end
    else
    begin
      state_q <= state_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      mid_rate_q <= mid_rate_d;
      fast_rate_q <= fast_rate_d;
      fast_off_q <= fast_off_d;
      scl_prev_q <= scl;
      sda_prev_q <= sda;
      mid_time_q <= mid_time_d; // Registered so the limiters see clean levels
      fast_time_q <= fast_time_d;
    end
  end

  // ==========================================================
  // Outputs; the data line is only ever pulled low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_q;
  assign MID_LEVEL_ATTACK_RATE = mid_rate_q;
  assign FAST_LEVEL_ATTACK_RATE = fast_rate_q;
  assign FAST_LEVEL_LIMITER_OFF = fast_off_q;
  assign MID_LEVEL_ATTACK_TIME = mid_time_q;
  assign FAST_LEVEL_ATTACK_TIME = fast_time_q;

endmodule : acfg_top

// ### verilog/acfg_pkg.sv
// Package of constants for the limiter attack configuration registers
package acfg_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] ACFG_MID_LEVEL_LIMITER_TIMING_ADDR = 8'h09;
  localparam logic [7:0] ACFG_FAST_LEVEL_LIMITER_CONTROL_ADDR = 8'h0A;

  // ==========================================================
  // Field positions
  localparam int ACFG_MID_RATE_LSB = 2;
  localparam int ACFG_MID_RATE_MSB = 4;
  localparam int ACFG_FAST_RATE_LSB = 2;
  localparam int ACFG_FAST_RATE_MSB = 3;
  localparam int ACFG_FAST_OFF_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [2:0] ACFG_MID_RATE_RST = 3'h2;
  localparam logic [1:0] ACFG_FAST_RATE_RST = 2'h1;
  localparam logic ACFG_FAST_OFF_RST = 1'b0;
  // Reserved bit patterns that reads always return
  localparam logic [2:0] ACFG_MID_RSVD_HI = 3'h0;
  localparam logic [1:0] ACFG_MID_RSVD_LO = 2'h0;
  localparam logic [3:0] ACFG_FAST_RSVD_HI = 4'h9;
  localparam logic ACFG_FAST_RSVD_B1 = 1'b1;

  // ==========================================================
  // Serial port constants
  localparam logic [6:0] ACFG_DEV_ADDR_DFLT = 7'h58; // Arbitrary device address
  localparam logic [3:0] ACFG_BITS_PER_BYTE = 4'h8;
  localparam int ACFG_RATE_W = 15;

  // ==========================================================
  // Attack rates in units of 10 us per dB
  function automatic logic [ACFG_RATE_W-1:0] acfg_mid_rate(input logic [2:0] code);
    logic [ACFG_RATE_W-1:0] r;
    r = 15'h0000;
    case (code)
      3'h0: r = 15'h0010; // 0.16 ms/dB
      3'h1: r = 15'h0020; // 0.32 ms/dB
      3'h2: r = 15'h0040; // 0.64 ms/dB
      3'h3: r = 15'h0100; // 2.56 ms/dB
      3'h4: r = 15'h0400; // 10.24 ms/dB
      3'h5: r = 15'h1004; // 41 ms/dB
      3'h6: r = 15'h2008; // 82 ms/dB
      default: r = 15'h4010; // 164 ms/dB
    endcase
    return r;
  endfunction : acfg_mid_rate

  function automatic logic [ACFG_RATE_W-1:0] acfg_fast_rate(input logic [1:0] code);
    logic [ACFG_RATE_W-1:0] r;
    r = 15'h0000;
    case (code)
      2'h0: r = 15'h0004; // 0.04 ms/dB
      2'h1: r = 15'h0008; // 0.08 ms/dB
      2'h2: r = 15'h0010; // 0.16 ms/dB
      default: r = 15'h0020; // 0.32 ms/dB
    endcase
    return r;
  endfunction : acfg_fast_rate

  // ==========================================================
  // Serial slave states
  typedef enum logic [3:0] {
    ACFG_IDLE,
    ACFG_ADDR,
    ACFG_ADDR_ACK,
    ACFG_PTR,
    ACFG_PTR_ACK,
    ACFG_WR,
    ACFG_WR_ACK,
    ACFG_RD,
    ACFG_RD_ACK
  } acfg_state_type;

endpackage : acfg_pkg

// ### verilog/acfg_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acfg_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  // ==========================================================
  // One filter per pin; idle level of a bus line is high
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      logic lvl_d;
      // Only the second and third stages are compared, the first is left alone
      always_comb
      begin
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
      end
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          lvl_q <= 1'b1;
        end
        else
        begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          lvl_q <= lvl_d;
        end
      end
      assign level_out[g] = lvl_q;
    end
  endgenerate
endmodule : acfg_pin_sync

// ### tb/acfg_checker.sv
// Port timing checker for the limiter attack registers
`timescale 1ns/1ps
module acfg_checker (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic [2:0] MID_LEVEL_ATTACK_RATE,
  input wire logic [1:0] FAST_LEVEL_ATTACK_RATE,
  input wire logic FAST_LEVEL_LIMITER_OFF,
  input wire logic [acfg_pkg::ACFG_RATE_W-1:0] MID_LEVEL_ATTACK_TIME,
  input wire logic [acfg_pkg::ACFG_RATE_W-1:0] FAST_LEVEL_ATTACK_TIME
);
  import acfg_pkg::*;
  // ====================
  // Expected rates in 10 us/dB units, kept apart from the design's tables
  localparam logic [14:0] MID_T [8] = '{15'h0010, 15'h0020, 15'h0040, 15'h0100,
    15'h0400, 15'h1004, 15'h2008, 15'h4010};
  localparam logic [14:0] FAST_T [4] = '{15'h0004, 15'h0008, 15'h0010, 15'h0020};
  // One clock domain, so clocking and reset are shared
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  // ====================
  // Properties
  property p_rst;
    $rose(ARST_N) |-> MID_LEVEL_ATTACK_RATE == 3'h2 && FAST_LEVEL_ATTACK_RATE == 2'h1
      && FAST_LEVEL_LIMITER_OFF == 1'b0 && SDA_OE == 1'b0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_mid_time;
    MID_LEVEL_ATTACK_TIME == MID_T[$past(MID_LEVEL_ATTACK_RATE)];
  endproperty
  a_mid_time: assert property (p_mid_time) else $error("mid time mismatch");
  property p_fast_time;
    FAST_LEVEL_ATTACK_TIME == FAST_T[$past(FAST_LEVEL_ATTACK_RATE)];
  endproperty
  a_fast_time: assert property (p_fast_time) else $error("fast time mismatch");
  // A setting may only move inside an acknowledged write byte
  property p_chg_ack;
    ($changed(MID_LEVEL_ATTACK_RATE) || $changed(FAST_LEVEL_ATTACK_RATE)
      || $changed(FAST_LEVEL_LIMITER_OFF)) |-> ##[0:8] SDA_OE;
  endproperty
  a_chg_ack: assert property (p_chg_ack) else $error("setting moved without ack");
  property p_chg_scl;
    ($changed(MID_LEVEL_ATTACK_RATE) || $changed(FAST_LEVEL_LIMITER_OFF)) |-> SCL_IN == 1'b0;
  endproperty
  a_chg_scl: assert property (p_chg_scl) else $error("setting moved with clock high");
  property p_oe_rise;
    $rose(SDA_OE) |-> SCL_IN == 1'b0;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("data pulled with clock high");
  property p_oe_hold;
    $rose(SCL_IN) |=> $stable(SDA_OE) [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data moved in clock high");
  property p_sda_out;
    SDA_OUT == 1'b0;
  endproperty
  a_sda_out: assert property (p_sda_out) else $error("open drain level wrong");
endmodule : acfg_checker

bind acfg_top acfg_checker u_chk (
  .SYS_CLK(SYS_CLK),
  .ARST_N(ARST_N),
  .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE),
  .MID_LEVEL_ATTACK_RATE(MID_LEVEL_ATTACK_RATE),
  .FAST_LEVEL_ATTACK_RATE(FAST_LEVEL_ATTACK_RATE),
  .FAST_LEVEL_LIMITER_OFF(FAST_LEVEL_LIMITER_OFF),
  .MID_LEVEL_ATTACK_TIME(MID_LEVEL_ATTACK_TIME),
  .FAST_LEVEL_ATTACK_TIME(FAST_LEVEL_ATTACK_TIME)
);

// ### tb/agc_attack_time_config_test.sv
// Self-checking bench for the limiter attack registers
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module agc_attack_time_config_test;
  import acfg_pkg::*;
  localparam logic [6:0] DEV = 7'h58; // Arbitrary address
  localparam logic [14:0] MID_T [8] = '{15'h0010, 15'h0020, 15'h0040, 15'h0100,
    15'h0400, 15'h1004, 15'h2008, 15'h4010};
  localparam logic [14:0] FAST_T [4] = '{15'h0004, 15'h0008, 15'h0010, 15'h0020};
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic sda_oe;
  logic [2:0] mid_rate;
  logic [1:0] fast_rate;
  logic fast_off;
  logic [14:0] mid_time;
  logic [14:0] fast_time;
  wire logic sda_w;
  int error_cnt = 0;
  int samples_checked = 0;
  // Open drain wire: the pull-up wins unless someone pulls low
  assign sda_w = sda_m & ~sda_oe;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  acfg_top #(.DEV_ADDR(DEV)) dut (
    .SYS_CLK(sys_clk),
    .ARST_N(arst_n),
    .SCL_IN(scl),
    .SDA_IN(sda_w),
    .SDA_OUT(),
    .SDA_OE(sda_oe),
    .MID_LEVEL_ATTACK_RATE(mid_rate),
    .FAST_LEVEL_ATTACK_RATE(fast_rate),
    .FAST_LEVEL_LIMITER_OFF(fast_off),
    .MID_LEVEL_ATTACK_TIME(mid_time),
    .FAST_LEVEL_ATTACK_TIME(fast_time)
  );
  // ====================
  // Serial master; every phase lasts 3, 8 or 10 clocks of the system clock
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wt
  task automatic start();
    wt(3);
    sda_m = 1'b1;
    wt(8);
    scl = 1'b1;
    wt(10);
    sda_m = 1'b0;
    wt(10);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    wt(3);
    sda_m = 1'b0;
    wt(8);
    scl = 1'b1;
    wt(10);
    sda_m = 1'b1;
    wt(10);
  endtask : stop
  task automatic xb(input logic b, output logic r);
    wt(3);
    sda_m = b;
    wt(8);
    scl = 1'b1;
    wt(10);
    r = sda_w;
    scl = 1'b0;
  endtask : xb
  task automatic tx(input logic [7:0] d, input logic ea);
    logic r;
    for (int i = 7; i >= 0; i--) xb(d[i], r);
    xb(1'b1, r);
    `CHK(~r, ea)
  endtask : tx
  task automatic rx(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xb(1'b1, r);
      d[i] = r;
    end
    xb(last, r); // Master NACK ends the read, ACK asks for more
  endtask : rx
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start();
    tx({DEV, 1'b0}, 1'b1);
    tx(p, 1'b1);
    tx(d, 1'b1);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    start();
    tx({DEV, 1'b0}, 1'b1);
    tx(p, 1'b1);
    start();
    tx({DEV, 1'b1}, 1'b1);
    rx(d, 1'b1);
    stop();
  endtask : rd
  // ====================
  // Scenarios
  task automatic t_reset();
    logic [7:0] d;
    `CHK(mid_rate, 3'h2)
    `CHK(fast_rate, 2'h1)
    `CHK(fast_off, 1'b0)
    `CHK(mid_time, 15'h0040)
    `CHK(fast_time, 15'h0008)
    rd(8'h09, d);
    `CHK(d, 8'h08)
    rd(8'h0A, d);
    `CHK(d, 8'h96)
  endtask : t_reset
  // Reserved bits are written as ones so any leak shows on readback
  task automatic t_mid();
    logic [7:0] d;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h09, {3'h7, c[2:0], 2'h3});
      `CHK(mid_rate, c[2:0])
      `CHK(mid_time, MID_T[c])
      rd(8'h09, d);
      `CHK(d, {3'h0, c[2:0], 2'h0})
    end
  endtask : t_mid
  task automatic t_fast();
    logic [7:0] d;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h0A, {4'h6, c[1:0], 1'b0, c[0]});
      `CHK(fast_rate, c[1:0])
      `CHK(fast_off, c[0])
      `CHK(fast_time, FAST_T[c])
      rd(8'h0A, d);
      `CHK(d, {4'h9, c[1:0], 1'b1, c[0]})
    end
  endtask : t_fast
  // Foreign address and unmapped pointer must leave settings alone
  task automatic t_bad();
    logic [7:0] d;
    start();
    tx({7'h21, 1'b0}, 1'b0);
    tx(8'h09, 1'b0);
    tx(8'h00, 1'b0);
    stop();
    wr(8'h0B, 8'h00);
    `CHK(mid_rate, 3'h7)
    `CHK(fast_rate, 2'h3)
    rd(8'h0B, d);
    `CHK(d, 8'h00)
  endtask : t_bad
  // Pointer steps on after each byte, for writes and reads alike
  task automatic t_burst();
    logic [7:0] d0;
    logic [7:0] d1;
    start();
    tx({DEV, 1'b0}, 1'b1);
    tx(8'h09, 1'b1);
    tx(8'h14, 1'b1);
    tx(8'h00, 1'b1);
    stop();
    `CHK(mid_rate, 3'h5)
    `CHK(fast_rate, 2'h0)
    `CHK(fast_off, 1'b0)
    start();
    tx({DEV, 1'b0}, 1'b1);
    tx(8'h09, 1'b1);
    start();
    tx({DEV, 1'b1}, 1'b1);
    rx(d0, 1'b0);
    rx(d1, 1'b1);
    stop();
    `CHK(d0, 8'h14)
    `CHK(d1, 8'h92)
  endtask : t_burst
  task automatic finish_test();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Main sequence, with a second reset in mid-run
  initial
  begin
    wt(8);
    arst_n = 1'b1;
    wt(4);
    t_reset();
    t_mid();
    t_fast();
    t_bad();
    t_burst();
    arst_n = 1'b0;
    wt(8);
    arst_n = 1'b1;
    wt(4);
    t_reset();
    finish_test();
  end
  // Watchdog against a hung run
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    finish_test();
  end
endmodule : agc_attack_time_config_test
